// ---- include/sic_defs.vh ----
// Purpose: Constants for the serial port interrupt and control block
// Assumes: Included by the top design file of the block only
// Notes: Register byte address is four times the register index
`ifndef SIC_DEFS_VH
`define SIC_DEFS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define SIC_IDX_PRIO 16'hFF20
`define SIC_IDX_IEN 16'hFF23
`define SIC_IDX_IFLG 16'hFF25
`define SIC_IDX_CFG 16'hFF48
`define SIC_IDX_CTL 16'hFF49
`define SIC_IDX_DATA 16'hFF4A

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SIC_PRIO_LO 4
`define SIC_PRIO_HI 5
`define SIC_SRC_TX 0
`define SIC_SRC_RX 1
`define SIC_SRC_ERR 2
`define SIC_CFG_PINS 0
`define SIC_CFG_MODE_LO 1
`define SIC_CFG_MODE_HI 2
`define SIC_CFG_CLK_LO 3
`define SIC_CFG_CLK_HI 4
`define SIC_CFG_PODD 5
`define SIC_CFG_PON 6
`define SIC_CTL_TX_ENABLE_BIT 0
`define SIC_CTL_TX_TRIGGER 1
`define SIC_CTL_RX_ENABLE_BIT 2
`define SIC_CTL_RX_TRIGGER 3
`define SIC_CTL_OVR 4
`define SIC_CTL_PAR 5
`define SIC_CTL_FRM 6
`define SIC_DATA_MSB 7

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define SIC_MODE_ASYNC8 2'h3
`define SIC_MODE_ASYNC7 2'h2
`define SIC_MODE_SLAVE 2'h1
`define SIC_MODE_MASTER 2'h0
`define SIC_CLK_TIMER 2'h3
`define SIC_CLK_DIV4 2'h2
`define SIC_CLK_DIV8 2'h1
`define SIC_CLK_DIV16 2'h0
`define SIC_RST_BYTE 8'h00
`define SIC_RST_MODE 2'h0
`define SIC_RST_CLK 2'h0
`define SIC_VEC_TX 24'h000014
`define SIC_VEC_RX 24'h000012
`define SIC_VEC_ERR 24'h000010
`define SIC_VEC_NONE 24'h000000

// ----------------------------------------
// Pin slots on the shared port
// ----------------------------------------
`define SIC_PIN_SIN 0
`define SIC_PIN_SERIAL_OUT_PIN 1
`define SIC_PIN_SCLK 2
`define SIC_PIN_SERIAL_READY_PIN 3

`endif

// ---- core/sic_sync.v ----
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module sic_sync #(
	parameter WIDTH = 4
) (
	input wire clk_i, // System clock
	input wire rst_i, // Synchronous reset, high
	input wire ce_i, // Clock enable
	input wire [WIDTH-1:0] d_i, // Asynchronous input
	output reg [WIDTH-1:0] q_o // Synchronised output
);
	reg [WIDTH-1:0] meta_reg;

	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= {WIDTH{1'b0}};
			q_o <= {WIDTH{1'b0}};
		end else if (ce_i) begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule

// ---- core/sic_flag.v ----
// Purpose: Sticky status flag with write-one-to-clear
// Assumes: All inputs on clk_i
// Notes: Set beats software clear; hold clear beats set
`timescale 1ns/1ps
module sic_flag (
	input wire clk_i, // System clock
	input wire rst_i, // Synchronous reset, high
	input wire ce_i, // Clock enable
	input wire set_i, // Event pulse
	input wire clr_i, // Software write of one
	input wire hold_i, // Force and hold at zero
	output reg flag_o // Flag state
);
	always @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else if (ce_i) begin
			if (hold_i) begin
				flag_o <= 1'b0;
			end else if (set_i) begin
				flag_o <= 1'b1;
			end else if (clr_i) begin
				flag_o <= 1'b0;
			end
		end
	end
endmodule

// ---- core/sic_top.v ----
// Purpose: Serial port interrupt flags, control registers and pin routing
// Assumes: Shift and framing datapath elsewhere, on clk_i, signals events
// Notes: Classic Wishbone slave, one wait state, 8-bit registers in low lane
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sic_defs.vh"
module sic_top (
	input wire clk_i, // System clock, 200 MHz
	input wire rst_i, // Synchronous reset, high
	input wire ce_i, // Clock enable, freezes state when low
	// Wishbone
	input wire cyc_i, // Bus cycle
	input wire stb_i, // Strobe
	input wire we_i, // Write enable
	input wire [17:0] adr_i, // Byte address
	input wire [3:0] sel_i, // Byte selects
	input wire [31:0] dat_i, // Write data
	output reg [31:0] dat_o, // Read data
	output reg ack_o, // Acknowledge
	// CPU interrupt side
	input wire [1:0] cpu_mask_i, // CPU interrupt mask level
	output reg irq_req_o, // Interrupt request
	output reg [23:0] irq_vector_o, // Vector of requesting source
	// Datapath events
	input wire tx_done_i, // Word fully sent
	input wire rx_load_i, // Word moved to receive buffer
	input wire [7:0] rx_data_i, // Received word
	input wire parity_err_i, // Parity mismatch on loaded word
	input wire framing_err_i, // Stop bit low on loaded word
	// Datapath controls
	output reg [1:0] xfer_mode_o, // Transfer mode
	output reg [1:0] clk_src_o, // Shift clock source
	output reg parity_on_o, // Parity active
	output reg parity_odd_sel_o, // Odd parity when high
	output reg tx_enable_o, // Transmit enable
	output reg rx_enable_o, // Receive enable
	output reg tx_start_o, // Transmit start pulse
	output reg rx_trigger_o, // Receive start or buffer freed pulse
	output reg [7:0] tx_data_o, // Word to send
	// Serial function signals
	input wire serial_out_i, // Serial data out
	input wire ser_clk_out_i, // Serial clock out
	input wire ser_clk_oe_i, // Serial clock drive
	input wire ser_rdy_out_i, // Ready out
	input wire ser_rdy_oe_i, // Ready drive
	output reg serial_in_o, // Serial data in
	output reg ser_clk_in_o, // Serial clock in
	output reg ser_rdy_in_o, // Ready in
	// General I/O side
	input wire [3:0] gpio_out_i, // Port output values
	input wire [3:0] gpio_oe_i, // Port output enables
	output reg [3:0] gpio_in_o, // Port input values
	// Shared pins
	input wire [3:0] shared_port_pins_i, // Pin levels
	output reg [3:0] shared_port_pins_o, // Pin drive values
	output reg [3:0] shared_port_pins_oe_o // Pin drive enables
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [7:0] prio_reg, ien_reg, tx_buf_reg, rx_buf_reg, rd_next;
	reg [1:0] mode_reg, clk_reg;
	reg pins_reg, podd_reg, pon_reg, tx_enable_bit_reg, rx_enable_bit_reg;
	reg tx_busy_reg, rx_busy_reg, rx_full_reg;
	reg [23:0] vec_next;

	wire [3:0] pin_sync;
	wire tx_done_flag, rx_done_flag, rx_error_flag;
	wire overrun_err_bit, parity_err_bit, framing_err_bit;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire [15:0] idx = adr_i[17:2];
	wire req = cyc_i & stb_i;
	wire wr = req & we_i & ack_o & sel_i[0];
	wire [7:0] wd = dat_i[7:0];
	wire wr_prio = wr & (idx == `SIC_IDX_PRIO);
	wire wr_ien = wr & (idx == `SIC_IDX_IEN);
	wire wr_iflg = wr & (idx == `SIC_IDX_IFLG);
	wire wr_cfg = wr & (idx == `SIC_IDX_CFG);
	wire wr_ctl = wr & (idx == `SIC_IDX_CTL);
	wire wr_data = wr & (idx == `SIC_IDX_DATA);

	wire [1:0] serial_prio = {prio_reg[`SIC_PRIO_HI], prio_reg[`SIC_PRIO_LO]};
	wire is_async = mode_reg[1];
	wire par_live = pon_reg & is_async;
	wire tx_trigger_wr = wr_ctl & wd[`SIC_CTL_TX_TRIGGER];
	wire rx_trigger_wr = wr_ctl & wd[`SIC_CTL_RX_TRIGGER];
	wire rx_enable_bit_next = wr_ctl ? wd[`SIC_CTL_RX_ENABLE_BIT] : rx_enable_bit_reg;

	// ----------------------------------------
	// Receive event qualification
	// ----------------------------------------
	// Overlap of buffer release and new load still counts as overrun
	wire ovr_evt = rx_load_i & rx_enable_bit_reg & is_async & (rx_full_reg | rx_trigger_wr);
	wire par_evt = rx_load_i & rx_enable_bit_reg & par_live & parity_err_i;
	wire frm_evt = rx_load_i & rx_enable_bit_reg & is_async & framing_err_i;
	wire rx_evt = rx_load_i & rx_enable_bit_reg & ~ovr_evt;
	wire err_evt = ovr_evt | par_evt | frm_evt;
	wire tx_evt = tx_done_i & tx_busy_reg;

	// ----------------------------------------
	// Sticky flags
	// ----------------------------------------
	sic_flag u_tx_flag (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.set_i(tx_evt),
		.clr_i(wr_iflg & wd[`SIC_SRC_TX]),
		.hold_i(1'b0), .flag_o(tx_done_flag));

	sic_flag u_rx_flag (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.set_i(rx_evt | par_evt | frm_evt),
		.clr_i(wr_iflg & wd[`SIC_SRC_RX]),
		.hold_i(1'b0), .flag_o(rx_done_flag));

	sic_flag u_err_flag (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.set_i(err_evt),
		.clr_i(wr_iflg & wd[`SIC_SRC_ERR]),
		.hold_i(1'b0), .flag_o(rx_error_flag));

	sic_flag u_ovr_bit (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.set_i(ovr_evt),
		.clr_i(wr_ctl & wd[`SIC_CTL_OVR]),
		.hold_i(~rx_enable_bit_next), .flag_o(overrun_err_bit));

	sic_flag u_par_bit (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.set_i(par_evt),
		.clr_i(wr_ctl & wd[`SIC_CTL_PAR]),
		.hold_i(~rx_enable_bit_next), .flag_o(parity_err_bit));

	sic_flag u_frm_bit (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.set_i(frm_evt),
		.clr_i(wr_ctl & wd[`SIC_CTL_FRM]),
		.hold_i(~rx_enable_bit_next), .flag_o(framing_err_bit));

	// ----------------------------------------
	// Pin input synchroniser
	// ----------------------------------------
	sic_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i(shared_port_pins_i),
		.q_o(pin_sync)
	);

	// ----------------------------------------
	// Bus slave and control registers
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			prio_reg <= `SIC_RST_BYTE;
			ien_reg <= `SIC_RST_BYTE;
			mode_reg <= `SIC_RST_MODE;
			clk_reg <= `SIC_RST_CLK;
			pins_reg <= 1'b0;
			podd_reg <= 1'b0;
			pon_reg <= 1'b0;
			tx_enable_bit_reg <= 1'b0;
			rx_enable_bit_reg <= 1'b0;
			tx_buf_reg <= `SIC_RST_BYTE;
		end else if (ce_i) begin
			ack_o <= req & ~ack_o;
			if (wr_prio) begin
				prio_reg <= wd;
			end
			if (wr_ien) begin
				ien_reg <= wd;
			end
			if (wr_cfg) begin
				pins_reg <= wd[`SIC_CFG_PINS];
				mode_reg <= wd[`SIC_CFG_MODE_HI:`SIC_CFG_MODE_LO];
				clk_reg <= wd[`SIC_CFG_CLK_HI:`SIC_CFG_CLK_LO];
				podd_reg <= wd[`SIC_CFG_PODD];
				pon_reg <= wd[`SIC_CFG_PON];
			end
			if (wr_ctl) begin
				tx_enable_bit_reg <= wd[`SIC_CTL_TX_ENABLE_BIT];
				rx_enable_bit_reg <= wd[`SIC_CTL_RX_ENABLE_BIT];
			end
			if (wr_data) begin
				tx_buf_reg <= wd;
			end
		end
	end

	// ----------------------------------------
	// Transfer status
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			tx_busy_reg <= 1'b0;
			rx_busy_reg <= 1'b0;
			rx_full_reg <= 1'b0;
			rx_buf_reg <= `SIC_RST_BYTE;
			tx_start_o <= 1'b0;
			rx_trigger_o <= 1'b0;
		end else if (ce_i) begin
			tx_start_o <= tx_trigger_wr & tx_enable_bit_reg & ~tx_busy_reg;
			rx_trigger_o <= rx_trigger_wr & rx_enable_bit_reg;
			if (wr_ctl & ~wd[`SIC_CTL_TX_ENABLE_BIT]) begin
				tx_busy_reg <= 1'b0;
			end else if (tx_trigger_wr & tx_enable_bit_reg) begin
				tx_busy_reg <= 1'b1;
			end else if (tx_evt) begin
				tx_busy_reg <= 1'b0;
			end
			if (~rx_enable_bit_next) begin
				rx_busy_reg <= 1'b0;
				rx_full_reg <= 1'b0;
			end else begin
				if (rx_trigger_wr) begin
					rx_busy_reg <= 1'b1;
				end else if (rx_load_i & ~is_async) begin
					rx_busy_reg <= 1'b0;
				end
				if (rx_load_i & rx_enable_bit_reg) begin
					rx_full_reg <= 1'b1;
				end else if (rx_trigger_wr) begin
					rx_full_reg <= 1'b0;
				end
			end
			if (rx_load_i & rx_enable_bit_reg) begin
				// Parity slot of 7-bit word loads as zero
				rx_buf_reg <= {rx_data_i[`SIC_DATA_MSB] &
					~(par_live & (mode_reg == `SIC_MODE_ASYNC7)),
					rx_data_i[`SIC_DATA_MSB-1:0]};
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		rd_next = `SIC_RST_BYTE;
		if (idx == `SIC_IDX_PRIO) begin
			rd_next = prio_reg;
		end else if (idx == `SIC_IDX_IEN) begin
			rd_next = ien_reg;
		end else if (idx == `SIC_IDX_IFLG) begin
			rd_next[`SIC_SRC_TX] = tx_done_flag;
			rd_next[`SIC_SRC_RX] = rx_done_flag;
			rd_next[`SIC_SRC_ERR] = rx_error_flag;
		end else if (idx == `SIC_IDX_CFG) begin
			rd_next[`SIC_CFG_PINS] = pins_reg;
			rd_next[`SIC_CFG_MODE_HI:`SIC_CFG_MODE_LO] = mode_reg;
			rd_next[`SIC_CFG_CLK_HI:`SIC_CFG_CLK_LO] = clk_reg;
			rd_next[`SIC_CFG_PODD] = podd_reg;
			rd_next[`SIC_CFG_PON] = pon_reg;
		end else if (idx == `SIC_IDX_CTL) begin
			rd_next[`SIC_CTL_TX_ENABLE_BIT] = tx_enable_bit_reg;
			rd_next[`SIC_CTL_TX_TRIGGER] = tx_busy_reg;
			rd_next[`SIC_CTL_RX_ENABLE_BIT] = rx_enable_bit_reg;
			rd_next[`SIC_CTL_RX_TRIGGER] = rx_busy_reg;
			rd_next[`SIC_CTL_OVR] = overrun_err_bit;
			rd_next[`SIC_CTL_PAR] = parity_err_bit;
			rd_next[`SIC_CTL_FRM] = framing_err_bit;
		end else if (idx == `SIC_IDX_DATA) begin
			rd_next = rx_buf_reg;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else if (ce_i) begin
			dat_o <= {24'h000000, rd_next};
		end
	end

	// ----------------------------------------
	// Interrupt request and vector
	// ----------------------------------------
	wire prio_ok = serial_prio > cpu_mask_i;
	wire req_tx = tx_done_flag & ien_reg[`SIC_SRC_TX];
	wire req_rx = rx_done_flag & ien_reg[`SIC_SRC_RX];
	wire req_err = rx_error_flag & ien_reg[`SIC_SRC_ERR];

	always @* begin
		vec_next = `SIC_VEC_NONE;
		if (req_err) begin
			vec_next = `SIC_VEC_ERR;
		end else if (req_rx) begin
			vec_next = `SIC_VEC_RX;
		end else if (req_tx) begin
			vec_next = `SIC_VEC_TX;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_o <= 1'b0;
			irq_vector_o <= `SIC_VEC_NONE;
		end else if (ce_i) begin
			irq_req_o <= prio_ok & (req_tx | req_rx | req_err);
			irq_vector_o <= prio_ok ? vec_next : `SIC_VEC_NONE;
		end
	end

	// ----------------------------------------
	// Control outputs and pin routing
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			xfer_mode_o <= `SIC_RST_MODE;
			clk_src_o <= `SIC_RST_CLK;
			parity_on_o <= 1'b0;
			parity_odd_sel_o <= 1'b0;
			tx_enable_o <= 1'b0;
			rx_enable_o <= 1'b0;
			tx_data_o <= `SIC_RST_BYTE;
			serial_in_o <= 1'b1;
			ser_clk_in_o <= 1'b1;
			ser_rdy_in_o <= 1'b1;
			gpio_in_o <= 4'h0;
			shared_port_pins_o <= 4'h0;
			shared_port_pins_oe_o <= 4'h0;
		end else if (ce_i) begin
			xfer_mode_o <= mode_reg;
			clk_src_o <= clk_reg;
			parity_on_o <= par_live;
			parity_odd_sel_o <= podd_reg & par_live;
			tx_enable_o <= tx_enable_bit_reg;
			rx_enable_o <= rx_enable_bit_reg;
			tx_data_o <= tx_buf_reg;
			gpio_in_o <= pin_sync;
			if (pins_reg) begin
				serial_in_o <= pin_sync[`SIC_PIN_SIN];
				ser_clk_in_o <= pin_sync[`SIC_PIN_SCLK];
				ser_rdy_in_o <= pin_sync[`SIC_PIN_SERIAL_READY_PIN];
				shared_port_pins_o[`SIC_PIN_SIN] <= 1'b0;
				shared_port_pins_oe_o[`SIC_PIN_SIN] <= 1'b0;
				shared_port_pins_o[`SIC_PIN_SERIAL_OUT_PIN] <= serial_out_i;
				shared_port_pins_oe_o[`SIC_PIN_SERIAL_OUT_PIN] <= 1'b1;
				shared_port_pins_o[`SIC_PIN_SCLK] <= ser_clk_out_i;
				shared_port_pins_oe_o[`SIC_PIN_SCLK] <= ser_clk_oe_i;
				shared_port_pins_o[`SIC_PIN_SERIAL_READY_PIN] <= ser_rdy_out_i;
				shared_port_pins_oe_o[`SIC_PIN_SERIAL_READY_PIN] <= ser_rdy_oe_i;
			end else begin
				serial_in_o <= 1'b1;
				ser_clk_in_o <= 1'b1;
				ser_rdy_in_o <= 1'b1;
				shared_port_pins_o <= gpio_out_i;
				shared_port_pins_oe_o <= gpio_oe_i;
			end
		end
	end
endmodule

// ---- testbench/sic_top_monitor.sv ----
// Purpose: Port checker for the serial port interrupt and control block
// Assumes: Bound to sic_top, one clock, synchronous reset high, ce_i held high
// Notes: Pin inputs reach the core after three clocks
`timescale 1ns/1ps
module sic_top_monitor (
	input wire clk_i, // Clock
	input wire rst_i, // Reset
	input wire cyc_i, // Bus cycle
	input wire stb_i, // Strobe
	input wire ack_o, // Acknowledge
	input wire [1:0] cpu_mask_i, // CPU mask
	input wire irq_req_o, // Request
	input wire [23:0] irq_vector_o, // Vector
	input wire [1:0] xfer_mode_o, // Mode
	input wire [1:0] clk_src_o, // Clock source
	input wire parity_on_o, // Parity on
	input wire parity_odd_sel_o, // Odd parity
	input wire tx_start_o, // Start pulse
	input wire serial_in_o, // Serial in
	input wire [3:0] gpio_in_o, // Port in
	input wire [3:0] shared_port_pins_i, // Pin levels
	input wire [3:0] shared_port_pins_oe_o // Pin enables
);
	// ----------------------------------------
	// Settling counter after reset
	// ----------------------------------------
	logic [1:0] run_reg;
	always @(posedge clk_i) begin
		if (rst_i)
			run_reg <= 2'h0;
		else if (run_reg != 2'h3)
			run_reg <= run_reg + 2'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_ack_wait;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_wait: assert property (p_ack_wait) else $error("ack late");
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_vec_set;
		irq_req_o |-> irq_vector_o inside {24'h000010, 24'h000012, 24'h000014};
	endproperty
	a_vec_set: assert property (p_vec_set) else $error("bad vector");
	property p_vec_none;
		!irq_req_o |-> irq_vector_o == 24'h000000;
	endproperty
	a_vec_none: assert property (p_vec_none) else $error("vector without request");
	property p_mask_top;
		irq_req_o |-> $past(cpu_mask_i) != 2'h3;
	endproperty
	a_mask_top: assert property (p_mask_top) else $error("request at top mask");
	property p_parity_async;
		parity_on_o || parity_odd_sel_o |-> xfer_mode_o[1];
	endproperty
	a_parity_async: assert property (p_parity_async) else $error("parity in sync");
	property p_gpio_follow;
		run_reg == 2'h3 |-> gpio_in_o == $past(shared_port_pins_i, 3);
	endproperty
	a_gpio_follow: assert property (p_gpio_follow) else $error("port in lag");
	property p_serial_pins;
		!serial_in_o |-> shared_port_pins_oe_o[1] && !shared_port_pins_oe_o[0];
	endproperty
	a_serial_pins: assert property (p_serial_pins) else $error("pin routing");
	property p_reset_vals;
		$fell(rst_i) |-> xfer_mode_o == 2'h0 && clk_src_o == 2'h0 && serial_in_o;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset value");
	property p_start_pulse;
		tx_start_o |=> !tx_start_o;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start too long");
endmodule

bind sic_top sic_top_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .cpu_mask_i,
	.irq_req_o, .irq_vector_o, .xfer_mode_o, .clk_src_o, .parity_on_o, .parity_odd_sel_o,
	.tx_start_o, .serial_in_o, .gpio_in_o, .shared_port_pins_i, .shared_port_pins_oe_o);

// ---- testbench/sic_peer.sv ----
// Purpose: Remote serial device sending one asynchronous frame
// Assumes: Line pulled up while idle
// Notes: Bit length is div_i plus one clocks
`timescale 1ns/1ps
module sic_peer (
	input wire clk_i, // Clock
	input wire go_i, // Start a frame
	input wire [3:0] div_i, // Clocks per bit minus one
	input wire [7:0] byte_i, // Word to send
	output wire line_o // Line level
);
	logic [9:0] sh_reg;
	logic [3:0] bits_reg = 4'h0;
	logic [3:0] cnt_reg = 4'h0;
	assign line_o = (bits_reg != 4'h0) ? sh_reg[0] : 1'h1;
	always @(posedge clk_i) begin
		if (go_i && bits_reg == 4'h0) begin
			sh_reg <= {1'h1, byte_i, 1'h0};
			bits_reg <= 4'hA;
			cnt_reg <= div_i;
		end else if (bits_reg != 4'h0) begin
			if (cnt_reg == 4'h0) begin
				sh_reg <= {1'h1, sh_reg[9:1]};
				bits_reg <= bits_reg - 4'h1;
				cnt_reg <= div_i;
			end else
				cnt_reg <= cnt_reg - 4'h1;
		end
	end
endmodule

// ---- testbench/test_serial_port_irq_and_control.sv ----
// Purpose: Self-checking bench for the serial port interrupt and control block
// Assumes: ce_i high, serial clock and ready lines idle
// Notes: Register byte address is index times four
`timescale 1ns/1ps
module test_serial_port_irq_and_control;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
	logic tx_done_i = 1'h0, rx_load_i = 1'h0, parity_err_i = 1'h0, framing_err_i = 1'h0;
	logic serial_out_i = 1'h1, go = 1'h0, sclk_oe = 1'h0;
	logic [17:0] adr_i = 18'h0;
	logic [31:0] dat_i = 32'h0, rdat;
	logic [3:0] sel_i = 4'h1, gpio_out_i = 4'h5, gpio_oe_i = 4'hA, div = 4'h0;
	logic [1:0] cpu_mask_i = 2'h0;
	logic [7:0] rx_data_i = 8'h0;
	wire [31:0] dat_o;
	wire ack_o, irq_req_o, parity_on_o, parity_odd_sel_o, tx_enable_o, rx_enable_o;
	wire tx_start_o, rx_trigger_o, serial_in_o, ser_clk_in_o, ser_rdy_in_o, peer_line;
	wire [23:0] irq_vector_o;
	wire [1:0] xfer_mode_o, clk_src_o;
	wire [7:0] tx_data_o;
	wire [3:0] gpio_in_o, shared_port_pins_i, shared_port_pins_o, shared_port_pins_oe_o;
	integer n_errors = 0, tests_run = 0, starts = 0, trigs = 0;
	always #2.5 clk_i = ~clk_i;
	assign shared_port_pins_i = (shared_port_pins_oe_o & shared_port_pins_o)
		| (~shared_port_pins_oe_o & {3'h7, peer_line});
	always @(posedge clk_i) begin
		if (tx_start_o === 1'h1)
			starts = starts + 1;
		if (rx_trigger_o === 1'h1)
			trigs = trigs + 1;
	end
	sic_top DUT (.clk_i, .rst_i, .ce_i(1'h1), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .cpu_mask_i, .irq_req_o, .irq_vector_o, .tx_done_i, .rx_load_i,
		.rx_data_i, .parity_err_i, .framing_err_i, .xfer_mode_o, .clk_src_o, .parity_on_o,
		.parity_odd_sel_o, .tx_enable_o, .rx_enable_o, .tx_start_o, .rx_trigger_o, .tx_data_o,
		.serial_out_i, .ser_clk_out_i(1'h1), .ser_clk_oe_i(sclk_oe), .ser_rdy_out_i(1'h1),
		.ser_rdy_oe_i(1'h0), .serial_in_o, .ser_clk_in_o, .ser_rdy_in_o, .gpio_out_i,
		.gpio_oe_i, .gpio_in_o, .shared_port_pins_i, .shared_port_pins_o, .shared_port_pins_oe_o);
	sic_peer u_peer (.clk_i, .go_i(go), .div_i(div), .byte_i(8'h00), .line_o(peer_line));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task test_done;
		begin
			$display("checks %0d errors %0d", tests_run, n_errors);
			if (n_errors == 0 && tests_run > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("mismatch %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	task bus(input logic [15:0] ix, input logic w, input logic [7:0] d);
		integer k;
		begin
			cyc_i <= 1'h1;
			stb_i <= 1'h1;
			we_i <= w;
			adr_i <= {ix, 2'h0};
			dat_i <= {24'h0, d};
			k = 0;
			@(posedge clk_i);
			while (ack_o !== 1'h1 && k < 20) begin
				@(posedge clk_i);
				k = k + 1;
			end
			if (k == 20) begin
				chk("bus ack", 32'h1, 32'h0);
				test_done;
			end
			rdat = dat_o;
			cyc_i <= 1'h0;
			stb_i <= 1'h0;
			we_i <= 1'h0;
			@(posedge clk_i);
		end
	endtask
	task rd(input string nm, input logic [15:0] ix, input logic [7:0] e);
		begin
			bus(ix, 1'h0, 8'h00);
			chk(nm, {24'h0, e}, rdat);
		end
	endtask
	task rx_ev(input logic [7:0] d, input logic p, input logic f);
		begin
			rx_load_i <= 1'h1;
			rx_data_i <= d;
			parity_err_i <= p;
			framing_err_i <= f;
			tick(1);
			rx_load_i <= 1'h0;
			parity_err_i <= 1'h0;
			framing_err_i <= 1'h0;
			tick(2);
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		begin
			rd("prio", 16'hFF20, 8'h00);
			rd("enables", 16'hFF23, 8'h00);
			rd("flags", 16'hFF25, 8'h00);
			rd("config", 16'hFF48, 8'h00);
			rd("control", 16'hFF49, 8'h00);
			chk("pin oe", 32'hA, {28'h0, shared_port_pins_oe_o});
			sel_i <= 4'h0;
			bus(16'hFF48, 1'h1, 8'h7F);
			sel_i <= 4'h1;
			bus(16'hFF21, 1'h1, 8'hFF);
			rd("lane off", 16'hFF48, 8'h00);
			rd("unmapped", 16'hFF21, 8'h00);
		end
	endtask
	task t_cfg;
		logic [1:0] i;
		begin
			for (int n = 0; n < 4; n++) begin
				i = n[1:0];
				bus(16'hFF48, 1'h1, {3'h3, i, i, 1'h0});
				rd("config", 16'hFF48, {3'h3, i, i, 1'h0});
				chk("mode", {30'h0, i}, {30'h0, xfer_mode_o});
				chk("clock", {30'h0, i}, {30'h0, clk_src_o});
				chk("parity", {31'h0, i[1]}, {31'h0, parity_on_o});
				chk("odd", {31'h0, i[1]}, {31'h0, parity_odd_sel_o});
			end
		end
	endtask
	task t_tx;
		begin
			bus(16'hFF49, 1'h1, 8'h01);
			bus(16'hFF4A, 1'h1, 8'h5A);
			chk("tx en", 32'h1, {31'h0, tx_enable_o});
			bus(16'hFF49, 1'h1, 8'h03);
			chk("tx data", 32'h5A, {24'h0, tx_data_o});
			rd("tx busy", 16'hFF49, 8'h03);
			chk("starts", 32'h1, starts);
			tx_done_i <= 1'h1;
			tick(1);
			tx_done_i <= 1'h0;
			tick(2);
			rd("tx idle", 16'hFF49, 8'h01);
			rd("tx flag", 16'hFF25, 8'h01);
			chk("irq off", 32'h0, {31'h0, irq_req_o});
		end
	endtask
	task t_irq;
		begin
			bus(16'hFF23, 1'h1, 8'h01);
			for (int l = 0; l < 4; l++) begin
				bus(16'hFF20, 1'h1, {2'h0, l[1:0], 4'h0});
				rd("prio", 16'hFF20, {2'h0, l[1:0], 4'h0});
				for (int m = 0; m < 4; m++) begin
					cpu_mask_i <= m[1:0];
					tick(3);
					chk("irq", {31'h0, l > m}, {31'h0, irq_req_o});
					chk("vector", (l > m) ? 32'h14 : 32'h0, {8'h0, irq_vector_o});
				end
			end
			cpu_mask_i <= 2'h0;
			bus(16'hFF25, 1'h1, 8'hFE);
			rd("kept", 16'hFF25, 8'h01);
			bus(16'hFF25, 1'h1, 8'h01);
			rd("cleared", 16'hFF25, 8'h00);
			chk("irq gone", 32'h0, {31'h0, irq_req_o});
		end
	endtask
	task t_rx;
		begin
			bus(16'hFF48, 1'h1, 8'h46);
			bus(16'hFF23, 1'h1, 8'h06);
			bus(16'hFF49, 1'h1, 8'h04);
			bus(16'hFF49, 1'h1, 8'h0C);
			rx_ev(8'hA5, 1'h0, 1'h0);
			rd("rx data", 16'hFF4A, 8'hA5);
			chk("rx en", 32'h1, {31'h0, rx_enable_o});
			rd("rx flag", 16'hFF25, 8'h02);
			chk("rx vector", 32'h12, {8'h0, irq_vector_o});
			bus(16'hFF25, 1'h1, 8'h02);
			rx_ev(8'h3C, 1'h0, 1'h0);
			rd("overrun", 16'hFF49, 8'h1C);
			rd("ovr flags", 16'hFF25, 8'h04);
			chk("err vector", 32'h10, {8'h0, irq_vector_o});
			bus(16'hFF49, 1'h1, 8'h1C);
			rd("ovr clear", 16'hFF49, 8'h0C);
			bus(16'hFF25, 1'h1, 8'h04);
			rx_ev(8'h11, 1'h1, 1'h0);
			rd("parity", 16'hFF49, 8'h2C);
			rd("par flags", 16'hFF25, 8'h06);
			bus(16'hFF49, 1'h1, 8'h2C);
			bus(16'hFF25, 1'h1, 8'h06);
			rx_ev(8'h22, 1'h0, 1'h1);
			rd("framing", 16'hFF49, 8'h4C);
			rd("frm flags", 16'hFF25, 8'h06);
			bus(16'hFF49, 1'h1, 8'h00);
			rd("rx off", 16'hFF49, 8'h00);
			chk("rx dis", 32'h0, {31'h0, rx_enable_o});
			chk("triggers", 32'h3, trigs);
		end
	endtask
	task t_pins;
		integer k;
		integer n;
		begin
			bus(16'hFF48, 1'h1, 8'h00);
			chk("port oe", 32'hA, {28'h0, shared_port_pins_oe_o});
			chk("port out", 32'h5, {28'h0, shared_port_pins_o});
			bus(16'hFF48, 1'h1, 8'h07);
			serial_out_i <= 1'h0;
			tick(2);
			chk("serial_out_pin oe", 32'h2, {30'h0, shared_port_pins_oe_o[1:0]});
			chk("serial_out_pin", 32'h0, {31'h0, shared_port_pins_o[1]});
			sclk_oe <= 1'h1;
			tick(2);
			chk("sclk oe", 32'h1, {31'h0, shared_port_pins_oe_o[2]});
			chk("sclk in", 32'h1, {31'h0, ser_clk_in_o});
			chk("rdy in", 32'h1, {31'h0, ser_rdy_in_o});
			for (int d = 0; d < 4; d += 3) begin
				div <= d[3:0];
				go <= 1'h1;
				tick(1);
				go <= 1'h0;
				n = 0;
				for (k = 0; k < 60; k++) begin
					@(posedge clk_i);
					if (serial_in_o === 1'h0)
						n = n + 1;
				end
				chk("frame low", 9 * (d + 1), n);
			end
		end
	endtask
	initial begin
		tick(4);
		rst_i <= 1'h0;
		tick(1);
		t_reset;
		t_cfg;
		t_tx;
		t_irq;
		t_rx;
		t_pins;
		test_done;
	end
endmodule
